// ==== hw/cmr_pkg.sv ====
/*
  Shared constants and types for the cell monitor protection register bank.
  Assumes a 10 MHz core clock and an I2C master on the SCL/SDA pins.
*/
package cmr_pkg;
  // Bus address of this slave
  localparam logic [6:0] DEV_ADDR = 7'h5d;

  // Register offsets
  localparam logic [7:0] REG_SLEEP = 8'h00;
  localparam logic [7:0] REG_BAL = 8'h01;
  localparam logic [7:0] REG_CMON = 8'h02;
  localparam logic [7:0] REG_SC1 = 8'h03;
  localparam logic [7:0] REG_SC2 = 8'h04;
  localparam logic [7:0] REG_ACT = 8'h05;
  localparam logic [7:0] REG_OT = 8'h06;
  localparam logic [7:0] REG_STAT = 8'h07;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_FLAG = 8'h09;

  // Writable bits; everything else reads zero
  localparam logic [7:0] WM_SLEEP = 8'hc0;
  localparam logic [7:0] WM_CMON = 8'he0;
  localparam logic [7:0] WM_SC1 = 8'hc7;
  localparam logic [7:0] WM_SC2 = 8'h1f;
  localparam logic [7:0] WM_ACT = 8'h07;
  localparam logic [7:0] WM_OT = 8'h93;
  localparam logic [7:0] WM_MASK = 8'h1d;

  // Power-on values
  localparam logic [7:0] RST_SLEEP = 8'h80;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SC1 = 8'h81;
  localparam logic [7:0] RST_SC2 = 8'h01;
  localparam logic [7:0] RST_ACT = 8'h03;
  localparam logic [7:0] RST_OT = 8'h92;

  // Field positions and codes
  localparam int B_CMON_EN = 7;
  localparam int B_ZERO = 6;
  localparam int B_GAIN = 5;
  localparam int B_OT_EN = 7;
  localparam int B_OT_LOCK = 4;
  localparam int B_HOST_WAKE = 2;
  localparam logic [1:0] SC_EN_ON = 2'h1;
  localparam logic [1:0] SLEEP_ON = 2'h1;

  // Timing in microseconds, and the derived core cycle counts
  localparam int CLK_KHZ = 10000;
  localparam int WAKE_FILT_US = 1000;
  localparam int DEB_STEP_US = 32;
  localparam int IRQ_PULSE_US = 5;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_US * CLK_KHZ + 999) / 1000;
  localparam int DEB_STEP_CYC = (DEB_STEP_US * CLK_KHZ + 999) / 1000;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_US * CLK_KHZ) / 1000;

  // One register write handed from the link to the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } cmr_wr_t;

  // Settings driven to the analog front end
  typedef struct packed {
    logic cmon_en;
    logic amp_zero;
    logic amp_gain_select;
    logic short_detect_on;
    logic [2:0] short_threshold_sel;
    logic [4:0] short_debounce_sel;
    logic overtemp_detect_enable;
    logic [1:0] overtemp_threshold_sel;
    logic sleep_active;
  } cmr_ana_t;

  // Link byte phases
  typedef enum {PH_ADDR, PH_REG, PH_WR, PH_RD, PH_IDLE} cmr_phase_t;
endpackage

// ==== hw/cmr_i2c_link.sv ====
/*
  I2C slave front end on the SCL clock: address match, pointer, byte
  shifting and acknowledge. Assumes SCL toggles only inside frames and
  that the core answers read requests within one byte time.
*/
`timescale 1ns/100ps
module cmr_i2c_link (
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic rstn,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_tog,
  output cmr_pkg::cmr_wr_t wr_word,
  output logic rd_tog,
  output logic [7:0] rd_addr,
  input wire logic rd_ack_tog,
  input wire logic [7:0] rd_data
);
  import cmr_pkg::*;

  logic start_tog;
  logic start_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] out_sr;
  logic [7:0] ptr;
  logic [7:0] rd_hold;
  logic ack;
  logic ack_s1;
  logic ack_s2;
  logic ack_q;
  cmr_phase_t phase;

  // Start seen on SDA falling with SCL high; SDA never moves near an SCL
  // rise in a legal frame, so the compare below is safe to sample.
  always_ff @(negedge sda_in or negedge rstn)
    if (!rstn)
      start_tog <= 1'b0;
    else if (scl_in)
      start_tog <= ~start_tog;

  wire new_start = start_tog ^ start_ack;
  wire [7:0] byte_in = {shift[6:0], sda_in};
  wire byte_done = (bit_cnt == 4'h7);
  wire ack_slot = (bit_cnt == 4'h8);
  wire [7:0] ptr_inc = ptr + 8'h01;
  assign sda_out = 1'b0;

  // Read answer word crosses by toggle handshake
  always_ff @(posedge scl_clk or negedge rstn)
    if (!rstn)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_q <= 1'b0;
      rd_hold <= 8'h00;
    end
    else
    begin
      ack_s1 <= rd_ack_tog;
      ack_s2 <= ack_s1;
      ack_q <= ack_s2;
      if (ack_s2 != ack_q)
        rd_hold <= rd_data;
    end

  // Byte framing and protocol phases
  always_ff @(posedge scl_clk or negedge rstn)
    if (!rstn)
    begin
      start_ack <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      out_sr <= 8'hff;
      ptr <= 8'h00;
      ack <= 1'b0;
      phase <= PH_IDLE;
      wr_tog <= 1'b0;
      wr_word <= '0;
      rd_tog <= 1'b0;
      rd_addr <= 8'h00;
    end
    else if (new_start)
    begin
      start_ack <= start_tog;
      bit_cnt <= 4'h1;
      shift <= {7'h00, sda_in};
      ack <= 1'b0;
      phase <= PH_ADDR;
    end
    else
    begin
      bit_cnt <= ack_slot ? 4'h0 : bit_cnt + 4'h1;
      shift <= byte_in;
      out_sr <= {out_sr[6:0], 1'b1};
      if (byte_done)
        case (phase)
          PH_ADDR:
          begin
            ack <= (byte_in[7:1] == DEV_ADDR);
            if (byte_in[7:1] != DEV_ADDR)
              phase <= PH_IDLE;
            else if (byte_in[0])
              phase <= PH_RD;
            else
              phase <= PH_REG;
          end
          PH_REG:
          begin
            ptr <= byte_in;
            rd_addr <= byte_in;
            rd_tog <= ~rd_tog;
            ack <= 1'b1;
            phase <= PH_WR;
          end
          PH_WR:
          begin
            wr_word <= '{addr: ptr, data: byte_in};
            wr_tog <= ~wr_tog;
            ptr <= ptr_inc;
            ack <= 1'b1;
          end
          default:
            ack <= 1'b0;
        endcase
      // Low on the slot means our own ack or the master wants more
      if (ack_slot && phase == PH_RD)
      begin
        if (!sda_in)
        begin
          out_sr <= rd_hold;
          ptr <= ptr_inc;
          rd_addr <= ptr_inc;
          rd_tog <= ~rd_tog;
        end
        else
          phase <= PH_IDLE;
      end
    end

  // SDA changes only while SCL is low
  wire drive_low = ack_slot ? ack : (phase == PH_RD && !out_sr[7]);
  always_ff @(negedge scl_clk or negedge rstn)
    if (!rstn)
      sda_oe <= 1'b0;
    else
      sda_oe <= drive_low;
endmodule

// ==== hw/cmr_regs_top.sv ====
/*
  Control and status register bank of the cell monitor protection logic,
  reached over I2C. Assumes analog comparators deliver logic levels for
  the short-current and over-temperature conditions and the wake pins.
*/
`timescale 1ns/100ps
// Behaviour
// - Balance enable bits 0..2 switch their cell balance switch on or off.
// - Current monitor bit 7 enables it; bit 6 grounds amplifier inputs.
// - Gain select bit 5 picks amplification 10 when 0, 50 when 1.
// - Short detection runs only for enable field code 01.
// - Three-bit code picks threshold 50 mV to 400 mV in 50 mV steps.
// - Interrupt line is held low while sensed voltage exceeds the threshold.
// - Debounce time equals five-bit code times 32 microseconds.
// - Set action bit makes a short event shut and latch its driver off.
// - Action bit takes a write only while its driver control input is low.
// - Latched-off driver is released by a falling edge on its control input.
// - Over-temperature enable bit 7; two-bit threshold 85/100/125/150 C.
// - Over-temperature with lock bit locks balance off until all cleared.
// - Status bits 7..5 show charge and discharge drivers on or off.
// - Over-temperature status follows the comparator with its hysteresis.
// - Wake status sets after 1 ms high, restoring sleep field; clears at once.
// - Reading the first wake bit shows only the pin event state.
// - Short status bit 0 reads 1 while sensed voltage exceeds threshold.
// - Mask bit 0 lets a status entry pulse the interrupt; 1 suppresses.
// - Flags set on status rising edge, clear after flag register read.
// - Slave address 1011101; pointer byte then data bytes, auto increment.
// - Sleep field enters sleep only for code 01; power-on value 10.
// - Balance switch stays on until written 0 or sleep is entered.
module cmr_regs_top #(
  parameter int WAKE_CYC = cmr_pkg::WAKE_FILT_CYC,
  parameter int DEB_STEP = cmr_pkg::DEB_STEP_CYC,
  parameter int IRQ_CYC = cmr_pkg::IRQ_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic charge_gate_ctrl_in,
  input wire logic discharge_ctrl_in1,
  input wire logic discharge_ctrl_in0,
  input wire logic hv_wake_pin1,
  input wire logic hv_wake_pin2,
  input wire logic sense_pos_in,
  input wire logic overtemp_hot_in,
  output logic charge_gate_out,
  output logic discharge_gate_out1,
  output logic discharge_gate_out0,
  output logic balance_en_cell1,
  output logic balance_en_cell2,
  output logic balance_en_cell3,
  output cmr_pkg::cmr_ana_t ana_ctrl,
  output logic irq_out_n
);
  import cmr_pkg::*;

  localparam logic [13:0] WAKE_LIM = 14'(WAKE_CYC);
  localparam logic [7:0] IRQ_LIM = 8'(IRQ_CYC);
  localparam int P_WR = 7;
  localparam int P_RD = 8;

  logic wr_tog;
  logic rd_tog;
  logic rd_ack_tog;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  cmr_wr_t wr_word;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic wr_q;
  logic rd_q;
  logic [7:0] sleep_reg;
  logic [7:0] bal;
  logic [7:0] cmon;
  logic [7:0] sc1;
  logic [7:0] sc2;
  logic [7:0] act;
  logic [7:0] ot;
  logic [7:0] mask;
  logic host_wake;
  logic bal_lock;
  logic sleep_q;
  logic [2:0] ctrl_q;
  logic [2:0] lock;
  logic [2:0] gate;
  logic [2:0] bal_out;
  logic [13:0] deb_cnt;
  logic [13:0] wake_cnt [2];
  logic [1:0] wake_st;
  logic [3:0] st_q;
  logic [3:0] flags;
  logic [7:0] pulse_cnt;

  cmr_i2c_link u_link (
    .scl_clk(scl_clk),
    .scl_in(scl_in),
    .rstn(rstn),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_tog(wr_tog),
    .wr_word(wr_word),
    .rd_tog(rd_tog),
    .rd_addr(rd_addr),
    .rd_ack_tog(rd_ack_tog),
    .rd_data(rd_data)
  );

  // Pins and link toggles enter the core clock through two flops
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end
    else
    begin
      sync1 <= {rd_tog, wr_tog, charge_gate_ctrl_in, discharge_ctrl_in1,
                discharge_ctrl_in0, hv_wake_pin2, hv_wake_pin1,
                sense_pos_in, overtemp_hot_in};
      sync2 <= sync1;
    end

  // Decoded synchronised inputs and write strobes
  wire hot_s = sync2[0];
  wire sense_s = sync2[1];
  wire [1:0] wake_pin_s = sync2[3:2];
  wire [2:0] ctrl_s = sync2[6:4];
  wire wr_ev = sync2[P_WR] ^ wr_q;
  wire rd_ev = sync2[P_RD] ^ rd_q;
  wire [7:0] wa = wr_word.addr;
  wire [7:0] wd = wr_word.data;
  wire wr_bal = wr_ev && wa == REG_BAL;
  wire wr_act = wr_ev && wa == REG_ACT;
  wire flag_rd = rd_ev && rd_addr == REG_FLAG;
  wire [7:0] ctrl8 = {5'h00, ctrl_s};

  // Detection and status terms
  wire short_on = (sc1[7:6] == SC_EN_ON);
  wire short_raw = sense_s && short_on;
  wire [13:0] deb_lim = 14'(int'(sc2[4:0]) * DEB_STEP);
  wire short_st = short_raw && deb_cnt >= deb_lim;
  wire ot_st = hot_s && ot[B_OT_EN];
  wire [3:0] st = {ot_st, wake_st[1], wake_st[0], short_st};
  wire [3:0] rise = st & ~st_q;
  wire [3:0] mask4 = {mask[4], mask[3], mask[2], mask[0]};
  wire wake_rise = rise[1] || rise[2];
  wire sleep_now = sleep_reg[7:6] == SLEEP_ON && wake_st == 2'h0 &&
                   !host_wake;

  // Handshake bookkeeping
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= sync2[P_WR];
      rd_q <= sync2[P_RD];
    end

  // Plain settings registers; reserved bits are never stored
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      cmon <= RST_ZERO;
      sc1 <= RST_SC1;
      sc2 <= RST_SC2;
      ot <= RST_OT;
      mask <= RST_ZERO;
      host_wake <= 1'b0;
    end
    else if (wr_ev)
      case (wa)
        REG_CMON: cmon <= wd & WM_CMON;
        REG_SC1: sc1 <= wd & WM_SC1;
        REG_SC2: sc2 <= wd & WM_SC2;
        REG_OT: ot <= wd & WM_OT;
        REG_MASK: mask <= wd & WM_MASK;
        REG_STAT: host_wake <= wd[B_HOST_WAKE];
        default: host_wake <= host_wake;
      endcase

  // Action bits change only where the driver control input is low
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      act <= RST_ACT;
    else if (wr_act)
      act <= (wd & WM_ACT & ~ctrl8) | (act & ctrl8);

  // Sleep field: a wake event restores the power-on code over any write
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      sleep_reg <= RST_SLEEP;
    else if (wake_rise)
      sleep_reg <= RST_SLEEP;
    else if (wr_ev && wa == REG_SLEEP)
      sleep_reg <= wd & WM_SLEEP;

  // Balance enables; entering sleep clears them so they stay off after
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      bal <= RST_ZERO;
    else if (sleep_now)
      bal <= RST_ZERO;
    else if (wr_bal)
      bal <= wd;

  // Thermal balance lock; a new event beats a same-cycle release
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      bal_lock <= 1'b0;
    else if (rise[3] && ot[B_OT_LOCK])
      bal_lock <= 1'b1;
    else if (wr_bal && wd == RST_ZERO)
      bal_lock <= 1'b0;

  // Short debounce: counter saturates at the selected limit
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      deb_cnt <= 14'h0000;
    else if (!short_raw)
      deb_cnt <= 14'h0000;
    else if (deb_cnt < deb_lim)
      deb_cnt <= deb_cnt + 14'h0001;

  // Wake filters: high for the full time sets, low clears at once
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      wake_cnt[0] <= 14'h0000;
      wake_cnt[1] <= 14'h0000;
      wake_st <= 2'h0;
    end
    else
      for (int i = 0; i < 2; i++)
        if (!wake_pin_s[i])
        begin
          wake_cnt[i] <= 14'h0000;
          wake_st[i] <= 1'b0;
        end
        else if (wake_cnt[i] >= WAKE_LIM)
          wake_st[i] <= 1'b1;
        else
          wake_cnt[i] <= wake_cnt[i] + 14'h0001;

  // Gate driver latches; set wins over the releasing falling edge
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      ctrl_q <= 3'h0;
      lock <= 3'h0;
      gate <= 3'h0;
    end
    else
    begin
      ctrl_q <= ctrl_s;
      lock <= (lock & ~(ctrl_q & ~ctrl_s))
              | ({3{rise[0]}} & act[2:0]);
      gate <= ctrl_s & ~lock & ~{3{sleep_q}};
    end

  // Flags, interrupt pulse and line; set wins over read clear
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      st_q <= 4'h0;
      flags <= 4'h0;
      pulse_cnt <= 8'h00;
      irq_out_n <= 1'b1;
    end
    else
    begin
      st_q <= st;
      flags <= (flags & ~{4{flag_rd}}) | rise;
      if (|(rise & ~mask4))
        pulse_cnt <= IRQ_LIM;
      else if (pulse_cnt != 8'h00)
        pulse_cnt <= pulse_cnt - 8'h01;
      irq_out_n <= !(pulse_cnt != 8'h00 || short_st);
    end

  // Register read view; the written wake bit never reads back
  function automatic logic [7:0] rd_view(input logic [7:0] a);
    case (a)
      REG_SLEEP: rd_view = sleep_reg;
      REG_BAL: rd_view = bal;
      REG_CMON: rd_view = cmon;
      REG_SC1: rd_view = sc1;
      REG_SC2: rd_view = sc2;
      REG_ACT: rd_view = act;
      REG_OT: rd_view = ot;
      REG_STAT: rd_view = {gate, ot_st, wake_st, 1'b0, short_st};
      REG_MASK: rd_view = mask;
      REG_FLAG: rd_view = {3'h0, flags[3:1], 1'b0, flags[0]};
      default: rd_view = 8'h00;
    endcase
  endfunction

  // Read answer and analog settings leave from flops
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      rd_data <= 8'h00;
      rd_ack_tog <= 1'b0;
      sleep_q <= 1'b0;
      bal_out <= 3'h0;
      ana_ctrl <= '0;
    end
    else
    begin
      if (rd_ev)
      begin
        rd_data <= rd_view(rd_addr);
        rd_ack_tog <= ~rd_ack_tog;
      end
      sleep_q <= sleep_now;
      bal_out <= bal[2:0] & ~{3{bal_lock || sleep_now}};
      ana_ctrl <= '{cmon_en: cmon[B_CMON_EN], amp_zero: cmon[B_ZERO],
                    amp_gain_select: cmon[B_GAIN], short_detect_on: short_on,
                    short_threshold_sel: sc1[2:0],
                    short_debounce_sel: sc2[4:0],
                    overtemp_detect_enable: ot[B_OT_EN],
                    overtemp_threshold_sel: ot[1:0],
                    sleep_active: sleep_now};
    end

  assign {charge_gate_out, discharge_gate_out1, discharge_gate_out0} = gate;
  assign {balance_en_cell3, balance_en_cell2, balance_en_cell1} = bal_out;

  // Checks on the core clock
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_short_rise;
    rise[0] && act[0];
  endsequence
  sequence s_flag_read;
    flag_rd && rise == 4'h0;
  endsequence

  property p_lock_drv;
    s_short_rise |=> ##1 !gate[0];
  endproperty
  a_lock_drv: assert property (p_lock_drv)
    else $error("discharge driver 0 not latched off");
  property p_act_hold;
    wr_act && ctrl_s[0] |=> act[0] == $past(act[0]);
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("action bit changed while control input high");
  property p_flag_set;
    rise[0] |=> flags[0];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("short flag not set on status rise");
  property p_flag_clr;
    s_flag_read |=> flags == 4'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flags not cleared by flag register read");
  property p_irq_short;
    short_st |=> !irq_out_n;
  endproperty
  a_irq_short: assert property (p_irq_short)
    else $error("interrupt line not low during short");
  property p_pulse;
    rise[3] && !mask[4] |=> ##1 !irq_out_n [*8];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("unmasked event gave no interrupt pulse");
  property p_bal_lock;
    rise[3] && ot[B_OT_LOCK] |=> ##1 bal_out == 3'h0;
  endproperty
  a_bal_lock: assert property (p_bal_lock)
    else $error("balance not locked off on over-temperature");
  property p_wake_sleep;
    wake_rise |=> sleep_reg[7:6] == RST_SLEEP[7:6];
  endproperty
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("sleep field not restored by wake");
  property p_release;
    $fell(ctrl_s[1]) && !rise[0] |=> !lock[1];
  endproperty
  a_release: assert property (p_release)
    else $error("driver 1 lock not released by falling edge");
endmodule

// ==== bench/cmr_i2c_host.sv ====
/*
  I2C master model standing in for the host controller.
  Assumes the bench resolves SDA as a wired-AND with a pull-up.
*/
`timescale 1ns/100ps
module cmr_i2c_host (
  output logic scl,
  output logic host_oe,
  input wire logic sda
);
  // Idle bus: SCL stands high between frames, SDA released
  initial
  begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    host_oe = 1'b0;
    #8 scl = 1'b1;
    #24 host_oe = 1'b1;
    #32 scl = 1'b0;
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop();
    #8 host_oe = 1'b1;
    #24 scl = 1'b1;
    #24 host_oe = 1'b0;
    #32;
  endtask
  // Nine bits MSB first; data moves well after SCL falls
  task automatic xfer(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      #8 host_oe = ~b[i];
      #24 scl = 1'b1;
      r[i] = sda;
      #32 scl = 1'b0;
    end
  endtask
endmodule

// ==== bench/testbench.sv ====
/*
  Self-checking bench for the register bank, driven over its I2C pins.
  Assumes the host model makes SCL and shares SDA with a pull-up.
*/
`timescale 1ns/100ps
module testbench;
  import cmr_pkg::*;
  logic core_clk, rstn, scl, host_oe, sda, sda_out, sda_oe;
  logic [2:0] ctl, gate, bal;
  logic wk1, wk2, sense, hot, irq_n;
  logic [7:0] n;
  logic [8:0] r9;
  cmr_ana_t ana;
  int miscompares, checks;
  logic [7:0] por [10] = '{8'h80, 8'h00, 8'h00, 8'h81, 8'h01, 8'h03,
    8'h92, 8'h00, 8'h00, 8'h00};
  // Wired-AND data line with pull-up
  assign sda = ~(sda_oe | host_oe);
  // Short counts keep the run brief
  cmr_regs_top #(.WAKE_CYC(20), .DEB_STEP(4), .IRQ_CYC(50)) u_cmr_regs_top (
    .core_clk(core_clk), .rstn(rstn), .scl_clk(scl), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .charge_gate_ctrl_in(ctl[2]), .discharge_ctrl_in1(ctl[1]),
    .discharge_ctrl_in0(ctl[0]), .hv_wake_pin1(wk1), .hv_wake_pin2(wk2),
    .sense_pos_in(sense), .overtemp_hot_in(hot),
    .charge_gate_out(gate[2]), .discharge_gate_out1(gate[1]),
    .discharge_gate_out0(gate[0]), .balance_en_cell1(bal[0]),
    .balance_en_cell2(bal[1]), .balance_en_cell3(bal[2]),
    .ana_ctrl(ana), .irq_out_n(irq_n));
  cmr_i2c_host u_cmr_i2c_host (.scl(scl), .host_oe(host_oe), .sda(sda));
  // Core clock, 100 ns
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Acks of all three bytes must be low
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] r;
    logic [2:0] k;
    u_cmr_i2c_host.start();
    u_cmr_i2c_host.xfer({DEV_ADDR, 2'b01}, r);
    k[0] = r[0];
    u_cmr_i2c_host.xfer({a, 1'b1}, r);
    k[1] = r[0];
    u_cmr_i2c_host.xfer({d, 1'b1}, r);
    k[2] = r[0];
    u_cmr_i2c_host.stop();
    cmp({5'h0, k}, 8'h00);
    repeat (5) @(negedge core_clk);
  endtask
  // Pointer write, repeated start, one byte read with NACK
  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
    logic [8:0] r;
    u_cmr_i2c_host.start();
    u_cmr_i2c_host.xfer({DEV_ADDR, 2'b01}, r);
    u_cmr_i2c_host.xfer({a, 1'b1}, r);
    u_cmr_i2c_host.start();
    u_cmr_i2c_host.xfer({DEV_ADDR, 2'b11}, r);
    u_cmr_i2c_host.xfer(9'h1ff, r);
    u_cmr_i2c_host.stop();
    cmp(r[8:1], exp);
    repeat (5) @(negedge core_clk);
  endtask
  // Bounded wait for the interrupt, then its length in core cycles
  task automatic irq_len(output logic [7:0] c);
    c = 8'h00;
    for (int t = 0; t < 400 && irq_n !== 1'b0; t++)
      @(negedge core_clk);
    while (irq_n === 1'b0 && c < 8'hff)
    begin
      c++;
      @(negedge core_clk);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {rstn, ctl, wk1, wk2, sense, hot} = '0;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 10; i++)
      rd_cmp(8'(i), por[i]);
    cmp({5'h0, ana.overtemp_detect_enable, ana.overtemp_threshold_sel},
      8'h06);
    // Foreign address gets no acknowledge
    u_cmr_i2c_host.start();
    u_cmr_i2c_host.xfer({7'h5c, 2'b01}, r9);
    u_cmr_i2c_host.stop();
    cmp({7'h0, r9[0]}, 8'h01);
    cmp({7'h0, sda_out}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      reg_wr(REG_CMON, 8'h80 >> i);
      cmp({5'h0, ana.cmon_en, ana.amp_zero, ana.amp_gain_select},
        8'h04 >> i);
    end
    reg_wr(REG_SC1, 8'hff);
    rd_cmp(REG_SC1, 8'hc7);
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(REG_SC1, {2'(k), 3'h0, 3'(k)});
      cmp({4'h0, ana.short_detect_on, ana.short_threshold_sel},
        {4'h0, k == 1, 3'(k)});
    end
    reg_wr(REG_SC2, 8'h1f);
    cmp({3'h0, ana.short_debounce_sel}, 8'h1f);
    reg_wr(REG_SC2, 8'h03);
    reg_wr(REG_SC1, 8'h47);
    // Drivers on; action bits refuse writes while controls are high
    ctl = 3'h7;
    repeat (5) @(negedge core_clk);
    cmp({5'h0, gate}, 8'h07);
    rd_cmp(REG_STAT, 8'he0);
    reg_wr(REG_ACT, 8'h00);
    rd_cmp(REG_ACT, 8'h03);
    // Short event: debounce of 12 cycles, then both discharges lock
    sense = 1'b1;
    repeat (8) @(negedge core_clk);
    cmp({7'h0, irq_n}, 8'h01);
    repeat (20) @(negedge core_clk);
    cmp({5'h0, gate}, 8'h04);
    cmp({7'h0, irq_n}, 8'h00);
    rd_cmp(REG_STAT, 8'h81);
    sense = 1'b0;
    repeat (60) @(negedge core_clk);
    cmp({7'h0, irq_n}, 8'h01);
    rd_cmp(REG_STAT, 8'h80);
    ctl[0] = 1'b0;
    repeat (5) @(negedge core_clk);
    ctl[0] = 1'b1;
    repeat (5) @(negedge core_clk);
    cmp({5'h0, gate}, 8'h05);
    ctl = 3'h0;
    repeat (5) @(negedge core_clk);
    reg_wr(REG_ACT, 8'h04);
    rd_cmp(REG_ACT, 8'h04);
    rd_cmp(REG_FLAG, 8'h01);
    rd_cmp(REG_FLAG, 8'h00);
    // Over-temperature locks balancing until all enables are cleared
    reg_wr(REG_BAL, 8'h07);
    cmp({5'h0, bal}, 8'h07);
    hot = 1'b1;
    repeat (10) @(negedge core_clk);
    cmp({5'h0, bal}, 8'h00);
    rd_cmp(REG_STAT, 8'h10);
    hot = 1'b0;
    reg_wr(REG_BAL, 8'h07);
    cmp({5'h0, bal}, 8'h00);
    reg_wr(REG_BAL, 8'h00);
    reg_wr(REG_BAL, 8'h07);
    cmp({5'h0, bal}, 8'h07);
    rd_cmp(REG_STAT, 8'h00);
    rd_cmp(REG_FLAG, 8'h10);
    reg_wr(REG_OT, 8'h01);
    cmp({5'h0, ana.overtemp_detect_enable, ana.overtemp_threshold_sel},
      8'h01);
    // Sleep, then wake by pin with one unmasked pulse
    reg_wr(REG_SLEEP, 8'h40);
    cmp({6'h0, ana.sleep_active, bal[0]}, 8'h02);
    repeat (60) @(negedge core_clk);
    wk1 = 1'b1;
    irq_len(n);
    cmp(n, 8'h32);
    rd_cmp(REG_SLEEP, 8'h80);
    reg_wr(REG_MASK, 8'h08);
    wk2 = 1'b1;
    irq_len(n);
    cmp(n, 8'h00);
    rd_cmp(REG_STAT, 8'h0c);
    wk1 = 1'b0;
    rd_cmp(REG_STAT, 8'h08);
    reg_wr(REG_STAT, 8'h04);
    rd_cmp(REG_STAT, 8'h08);
    reg_wr(REG_STAT, 8'h00);
    reg_wr(REG_SLEEP, 8'h80);
    rd_cmp(REG_FLAG, 8'h0c);
    rd_cmp(REG_FLAG, 8'h00);
    tally_and_finish();
  end
endmodule
